// [core/tic_top.sv]
// Time interval counter: time-of-day chain, interval counter and control register.
// Assumes software drives the one-cycle register port synchronously to SYS_CLK.
`timescale 1ns/1ps
module tic_top #(
	parameter int DIVIDE = tic_pkg::SUBSEC_DIV
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [tic_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic INTERVAL_FLAG,
	output logic SUBSEC_TICK
);
	import tic_pkg::*;
	tic_bus_s bus;
	tic_state_s s_reg;
	tic_state_s s_next;
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign RDATA = s_reg.rdata;
	assign INTERVAL_FLAG = s_reg.control[BIT_FLAG];
	assign SUBSEC_TICK = s_reg.tick_out;

	always_comb begin
		logic run;
		logic tick;
		logic c_sec;
		logic c_min;
		logic c_hour;
		logic unit;
		logic match;
		logic [7:0] hour_last;
		run = 1'b0;
		tick = 1'b0;
		c_sec = 1'b0;
		c_min = 1'b0;
		c_hour = 1'b0;
		unit = 1'b0;
		match = 1'b0;
		hour_last = 8'h00;
		s_next = s_reg;
		s_next.tick_out = 1'b0;
		run = s_reg.control[BIT_CLK_EN];
		// The divider is cleared while stopped so the first tick after enable is a full period.
		if (run) begin //RL7
			if (s_reg.div >= 32'(DIVIDE - 1)) begin
				s_next.div = 32'h0;
				tick = 1'b1;
			end else begin
				s_next.div = s_reg.div + 32'h1;
			end
		end else begin
			s_next.div = 32'h0;
		end
		s_next.tick_out = tick;
		hour_last = s_reg.control[BIT_TFH] ? HOUR_LAST_24 : HOUR_LAST_FULL; //RL1
		if (tick) begin //RL12
			c_sec = (s_reg.subsec >= SUBSEC_LAST);
			s_next.subsec = c_sec ? 8'h00 : s_reg.subsec + 8'h01;
			if (c_sec) begin
				c_min = (s_reg.sec >= SEC_LAST);
				s_next.sec = c_min ? 8'h00 : s_reg.sec + 8'h01;
			end
			if (c_min) begin
				c_hour = (s_reg.min >= MIN_LAST);
				s_next.min = c_hour ? 8'h00 : s_reg.min + 8'h01;
			end
			if (c_hour) begin
				s_next.hour = (s_reg.hour >= hour_last) ? 8'h00 : s_reg.hour + 8'h01; //RL1
			end
		end
		case (s_reg.control[BIT_TB_HI:BIT_TB_LO]) //RL2
			TB_SUBSEC: unit = tick;
			TB_SEC: unit = c_sec;
			TB_MIN: unit = c_min;
			TB_HOUR: unit = c_hour;
			default: unit = 1'b0;
		endcase
		if (!s_reg.control[BIT_INT_EN]) begin
			s_next.interval = 8'h00; //RL11
		end else if (unit) begin //RL6
			if (s_reg.interval + 8'h01 == s_reg.compare) begin
				match = 1'b1; //RL5
				s_next.interval = 8'h00; //RL4
				if (s_reg.control[BIT_SINGLE]) begin
					s_next.control[BIT_INT_EN] = 1'b0; //RL3
				end
			end else begin
				s_next.interval = s_reg.interval + 8'h01; //RL11
			end
		end
		if (bus.wr) begin
			case (bus.addr)
				OFS_CONTROL: begin
					s_next.control = bus.wdata & CONTROL_MASK; //RL10
					// Flag can only be cleared by software; a match in the same cycle still sets it.
					s_next.control[BIT_FLAG] = s_reg.control[BIT_FLAG] & bus.wdata[BIT_FLAG];
					if (bus.wdata[BIT_INT_EN] && !s_reg.control[BIT_INT_EN]) begin
						s_next.interval = 8'h00; //RL11
					end
					if (!bus.wdata[BIT_CLK_EN]) begin //RL8
						s_next.subsec = s_reg.w_subsec;
						s_next.sec = s_reg.w_sec;
						s_next.min = s_reg.w_min;
						s_next.hour = s_reg.w_hour;
					end
				end
				OFS_SUBSEC: begin //RL9
					s_next.w_subsec = bus.wdata;
					s_next.subsec = bus.wdata;
				end
				OFS_SEC: begin
					s_next.w_sec = bus.wdata;
					s_next.sec = bus.wdata;
				end
				OFS_MIN: begin
					s_next.w_min = bus.wdata;
					s_next.min = bus.wdata;
				end
				OFS_HOUR: begin
					s_next.w_hour = bus.wdata;
					s_next.hour = bus.wdata;
				end
				OFS_COMPARE: s_next.compare = bus.wdata;
				default: s_next.compare = s_next.compare;
			endcase
		end
		if (match) begin
			s_next.control[BIT_FLAG] = 1'b1; //RL5
		end
		s_next.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				OFS_CONTROL: s_next.rdata = s_reg.control & CONTROL_MASK; //RL10
				OFS_SUBSEC: s_next.rdata = s_reg.subsec;
				OFS_SEC: s_next.rdata = s_reg.sec;
				OFS_MIN: s_next.rdata = s_reg.min;
				OFS_HOUR: s_next.rdata = s_reg.hour;
				OFS_COMPARE: s_next.rdata = s_reg.compare;
				OFS_INTERVAL: s_next.rdata = s_reg.interval;
				default: s_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			s_reg <= '0;
			s_reg.control <= CONTROL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// [core/tic_pkg.sv]
// Constants, register map and state carrier for the time interval counter control.
// Assumes a single 40 MHz clock and a plain one-cycle register port from software.
// What this block does
// RL1: Hour wraps at 23 or 255 by select.
// RL2: Two-bit field picks interval counting unit.
// RL3: Single mode timeout clears interval enable.
// RL4: Repeat mode reloads and restarts after timeout.
// RL5: Match with compare sets sticky interrupt flag.
// RL6: Interval counter counts only while enabled.
// RL7: Clock enable low freezes time and interval counters; the divider is cleared.
// RL8: Clock enable low restores last written values.
// RL9: Software writes time while clock disabled.
// RL10: Control bit seven ignored, reads zero.
// RL11: Interval counts per selected unit, zero on enable.
// RL12: Sub-second wraps 127, seconds minutes 59.
package tic_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFS_CONTROL = 3'h0;
	localparam logic [2:0] OFS_SUBSEC = 3'h1;
	localparam logic [2:0] OFS_SEC = 3'h2;
	localparam logic [2:0] OFS_MIN = 3'h3;
	localparam logic [2:0] OFS_HOUR = 3'h4;
	localparam logic [2:0] OFS_COMPARE = 3'h5;
	localparam logic [2:0] OFS_INTERVAL = 3'h6;
	localparam int BIT_CLK_EN = 0;
	localparam int BIT_INT_EN = 1;
	localparam int BIT_FLAG = 2;
	localparam int BIT_SINGLE = 3;
	localparam int BIT_TB_LO = 4;
	localparam int BIT_TB_HI = 5;
	localparam int BIT_TFH = 6;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_MASK = 8'h7f;
	localparam logic [1:0] TB_SUBSEC = 2'h0;
	localparam logic [1:0] TB_SEC = 2'h1;
	localparam logic [1:0] TB_MIN = 2'h2;
	localparam logic [1:0] TB_HOUR = 2'h3;
	localparam logic [7:0] SUBSEC_LAST = 8'h7f;
	localparam logic [7:0] SEC_LAST = 8'h3b;
	localparam logic [7:0] MIN_LAST = 8'h3b;
	localparam logic [7:0] HOUR_LAST_24 = 8'h17;
	localparam logic [7:0] HOUR_LAST_FULL = 8'hff;
	localparam int CLK_HZ = 40000000;
	localparam int TICKS_PER_SEC = 128;
	localparam int SUBSEC_DIV = CLK_HZ / TICKS_PER_SEC;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tic_bus_s;
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] subsec;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] w_subsec;
		logic [7:0] w_sec;
		logic [7:0] w_min;
		logic [7:0] w_hour;
		logic [7:0] compare;
		logic [7:0] interval;
		logic [31:0] div;
		logic [7:0] rdata;
		logic tick_out;
	} tic_state_s;
endpackage

// [dv/tic_top_sva.sv]
// Port checker for the time interval counter control.
// Assumes a master that never raises RD and WR together.
`timescale 1ns/1ps
module tic_top_sva (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [tic_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic INTERVAL_FLAG,
	input wire logic SUBSEC_TICK
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	sequence clk_off_s;
		(WR && ADDR == 3'h0 && !WDATA[0]) ##1 !WR [*3];
	endsequence
	chk_bit7_zero: assert property (RD && ADDR == 3'h0 |=> !RDATA[7]) else $error("bit7 set");
	chk_flag_sticky: assert property (INTERVAL_FLAG && !(WR && ADDR == 3'h0 && !WDATA[2])
		|=> INTERVAL_FLAG) else $error("flag dropped");
	chk_tick_gated: assert property (clk_off_s |=> !SUBSEC_TICK) else $error("tick when off");
	chk_compare_back: assert property (WR && ADDR == 3'h5 ##1 RD && ADDR == 3'h5
		|=> RDATA == $past(WDATA, 2)) else $error("compare lost");
	chk_tick_pulse: assert property (SUBSEC_TICK |=> !SUBSEC_TICK) else $error("tick long");
	chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata idle");
	chk_unmapped_zero: assert property (RD && ADDR == 3'h7 |=> RDATA == 8'h00) else $error("idx7");
	chk_reset_quiet: assert property ($fell(SYS_RST) |-> !INTERVAL_FLAG && RDATA == 8'h00)
		else $error("reset state");
	cover property (INTERVAL_FLAG);
	cover property (SUBSEC_TICK);
	cover property (RD && ADDR == 3'h6);
endmodule
bind tic_top tic_top_sva tic_top_sva_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INTERVAL_FLAG(INTERVAL_FLAG),
	.SUBSEC_TICK(SUBSEC_TICK));

// [dv/tic_top_test.sv]
// Self-checking bench for the time interval counter control.
// Assumes a divider of 4, so one sub-second tick is four clocks.
`timescale 1ns/1ps
module tic_top_test;
	import tic_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, flag, tick;
	logic [ADDR_W-1:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata;
	int err_total = 0, total_checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	tic_top #(.DIVIDE(4)) tic_top_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .INTERVAL_FLAG(flag), .SUBSEC_TICK(tick));
	// Each call holds its strobes for exactly one edge; the next call drives them again, high or low.
	task bus(input logic [2:0] a, input logic [7:0] d, input logic w, input logic r);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= r;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task idle(input int n);
		repeat (n) bus(3'h0, 8'h00, 1'b0, 1'b0);
	endtask
	task rdc(input logic [2:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b0, 1'b1);
		bus(a, 8'h00, 1'b0, 1'b0);
		#1 chk(rdata, e);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rdc(3'h7, 8'h00);
		bus(3'h0, 8'h80, 1'b1, 1'b0);
		rdc(3'h0, 8'h00);
		bus(3'h5, 8'h02, 1'b1, 1'b0);
		rdc(3'h5, 8'h02);
		bus(3'h1, SUBSEC_LAST, 1'b1, 1'b0);
		bus(3'h2, SEC_LAST, 1'b1, 1'b0);
		bus(3'h3, MIN_LAST, 1'b1, 1'b0);
		bus(3'h4, HOUR_LAST_24, 1'b1, 1'b0);
		bus(3'h0, 8'h41, 1'b1, 1'b0);
		idle(8);
		rdc(3'h2, 8'h00);
		rdc(3'h3, 8'h00);
		rdc(3'h4, 8'h00);
		bus(3'h0, 8'h00, 1'b1, 1'b0);
		idle(10);
		rdc(3'h1, SUBSEC_LAST);
		rdc(3'h4, HOUR_LAST_24);
		bus(3'h0, 8'h01, 1'b1, 1'b0);
		idle(8);
		rdc(3'h4, 8'h18);
		bus(3'h0, 8'h0b, 1'b1, 1'b0);
		idle(12);
		#1 chk({7'h00, flag}, 8'h01);
		rdc(3'h0, 8'h0d);
		bus(3'h0, 8'h01, 1'b1, 1'b0);
		idle(20);
		#1 chk({7'h00, flag}, 8'h00);
		rdc(3'h6, 8'h00);
		bus(3'h0, 8'h03, 1'b1, 1'b0);
		idle(30);
		rdc(3'h0, 8'h07);
		bus(3'h0, 8'h03, 1'b1, 1'b0);
		idle(12);
		#1 chk({7'h00, flag}, 8'h01);
		// Disable first so the count starts from zero while the clock is stopped.
		bus(3'h0, 8'h00, 1'b1, 1'b0);
		bus(3'h0, 8'h02, 1'b1, 1'b0);
		idle(40);
		#1 chk({7'h00, flag}, 8'h00);
		rdc(3'h6, 8'h00);
		bus(3'h0, 8'h13, 1'b1, 1'b0);
		idle(500);
		#1 chk({7'h00, flag}, 8'h00);
		idle(600);
		#1 chk({7'h00, flag}, 8'h01);
		bus(3'h0, 8'h31, 1'b1, 1'b0);
		bus(3'h0, 8'h33, 1'b1, 1'b0);
		idle(40);
		rdc(3'h6, 8'h00);
		wrap_up();
	end
endmodule
